// ==== rtl/dli_interp.sv ====
// Interpolator pair with AHB-Lite register slave
`timescale 1ns/1ps
`include "dli_cfg.svh"
module dli_interp (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	// Shift, mask and optional sign extension of one lane
	function automatic dli_pkg::dli_word_t lane_value(
		input dli_pkg::dli_word_t din, input dli_pkg::dli_word_t c);
		dli_pkg::dli_word_t sh;
		dli_pkg::dli_word_t hi;
		dli_pkg::dli_word_t v;
		logic [4:0] lo_pos;
		logic [4:0] hi_pos;
		lo_pos = c[`DLI_F_MLOW +: 5];
		hi_pos = c[`DLI_F_MHIGH +: 5];
		sh = din >> c[`DLI_F_SHIFT +: 5]; // RQ8
		hi = 32'hFFFFFFFF >> (5'h1F - hi_pos);
		v = sh & hi & (32'hFFFFFFFF << lo_pos); // RQ9
		if (c[`DLI_B_SIGNED] && v[hi_pos]) begin
			v = v | ~hi; // RQ10
		end
		return v;
	endfunction

	// Comparison with selectable signedness
	function automatic logic less(input dli_pkg::dli_word_t a,
		input dli_pkg::dli_word_t b, input logic sgn);
		return sgn ? ($signed(a) < $signed(b)) : (a < b);
	endfunction

	// Blend of two bases by an 8 bit fraction, 40 bit intermediate
	function automatic dli_pkg::dli_word_t blend(input dli_pkg::dli_word_t b0,
		input dli_pkg::dli_word_t b1, input logic [7:0] alpha,
		input logic sgn);
		logic [39:0] e0;
		logic [39:0] e1;
		logic [39:0] d;
		logic signed [48:0] p;
		logic [39:0] sum;
		e0 = sgn ? {{8{b0[31]}}, b0} : {8'h00, b0};
		e1 = sgn ? {{8{b1[31]}}, b1} : {8'h00, b1};
		d = e1 - e0;
		p = $signed(d) * $signed({1'b0, alpha});
		sum = e0 + p[47:8];
		return sum[31:0];
	endfunction

	dli_pkg::dli_state_s s_reg; // Registered state
	dli_pkg::dli_state_s s_next; // Next state
	dli_pkg::dli_word_t lin [2][2]; // Selected lane inputs
	dli_pkg::dli_word_t lval [2][2]; // Shift and mask values
	dli_pkg::dli_word_t res [2][3]; // Results per unit
	dli_pkg::dli_word_t rd_mux; // Read data for the captured address
	logic take; // Address phase accepted
	logic [5:0] ofs; // Word offset inside a unit
	logic unit; // Addressed unit

	// Lane datapath and the three results of each unit
	always_comb begin
		for (int u = 0; u < 2; u++) begin
			// Input swap picks the opposite accumulator
			lin[u][0] = s_reg.ctrl[u][0][`DLI_B_XINPUT] ?
				s_reg.acc[u][1] : s_reg.acc[u][0]; // RQ13 RQ14
			lin[u][1] = s_reg.ctrl[u][1][`DLI_B_XINPUT] ?
				s_reg.acc[u][0] : s_reg.acc[u][1]; // RQ13 RQ14
			for (int l = 0; l < 2; l++) begin
				lval[u][l] = lane_value(lin[u][l], s_reg.ctrl[u][l]);
			end
			// Bypass adds the raw input, the third sum never does
			res[u][0] = s_reg.base[u][0] + (s_reg.ctrl[u][0][`DLI_B_BYPASS] ?
				lin[u][0] : lval[u][0]); // RQ6 RQ7 RQ15
			res[u][1] = s_reg.base[u][1] + (s_reg.ctrl[u][1][`DLI_B_BYPASS] ?
				lin[u][1] : lval[u][1]); // RQ6 RQ7 RQ15
			res[u][2] = s_reg.base[u][2] + lval[u][0] + lval[u][1]; // RQ7
		end
		// First unit: linear blend mode
		if (s_reg.ctrl[0][0][`DLI_B_MODE]) begin
			res[0][0] = {24'h000000, lval[0][1][7:0]}; // RQ18
			res[0][1] = blend(s_reg.base[0][0], s_reg.base[0][1],
				lval[0][1][7:0], s_reg.ctrl[0][1][`DLI_B_SIGNED]); // RQ18
			res[0][2] = s_reg.base[0][2] + lval[0][0]; // RQ16
		end
		// Second unit: range limit mode, no addition
		if (s_reg.ctrl[1][0][`DLI_B_MODE]) begin
			if (less(s_reg.base[1][1], lval[1][0],
				s_reg.ctrl[1][0][`DLI_B_SIGNED])) begin
				res[1][0] = s_reg.base[1][1]; // RQ17
			end else if (less(lval[1][0], s_reg.base[1][0],
				s_reg.ctrl[1][0][`DLI_B_SIGNED])) begin
				res[1][0] = s_reg.base[1][0]; // RQ17
			end else begin
				res[1][0] = lval[1][0]; // RQ17
			end
		end
	end

	// Read multiplexer over the captured address; unmapped reads zero
	always_comb begin
		ofs = s_reg.addr[5:0];
		unit = s_reg.addr[`DLI_UNIT_BIT];
		unique case (ofs)
			`DLI_OFS_ACC0: rd_mux = s_reg.acc[unit][0];
			`DLI_OFS_ACC1: rd_mux = s_reg.acc[unit][1];
			`DLI_OFS_ADDEND_REG_ZERO: rd_mux = s_reg.base[unit][0];
			`DLI_OFS_ADDEND_REG_ONE: rd_mux = s_reg.base[unit][1];
			`DLI_OFS_ADDEND_REG_TWO: rd_mux = s_reg.base[unit][2];
			`DLI_OFS_VIEW0, `DLI_OFS_ADV0: rd_mux = res[unit][0]; // RQ4 RQ5
			`DLI_OFS_VIEW1, `DLI_OFS_ADV1: rd_mux = res[unit][1]; // RQ4 RQ5
			`DLI_OFS_VIEW2, `DLI_OFS_ADV2: rd_mux = res[unit][2]; // RQ4 RQ5
			`DLI_OFS_CTRL0: rd_mux = s_reg.ctrl[unit][0];
			`DLI_OFS_CTRL1: rd_mux = s_reg.ctrl[unit][1];
			`DLI_OFS_ADD0: rd_mux = lval[unit][0]; // RQ11
			`DLI_OFS_ADD1: rd_mux = lval[unit][1]; // RQ11
			default: rd_mux = `DLI_WORD_RESET;
		endcase
	end

	// Next state: bus phases, register writes and result advance
	always_comb begin
		s_next = s_reg;
		take = hsel && htrans[1] && hready;
		unique case (s_reg.phase)
			// A read waits one cycle so a preceding write has landed
			dli_pkg::DLI_RD_WAIT: begin
				s_next.rdata = rd_mux; // RQ2
				s_next.phase = dli_pkg::DLI_RD_DONE;
				if (ofs == `DLI_OFS_ADV0 || ofs == `DLI_OFS_ADV1 ||
					ofs == `DLI_OFS_ADV2) begin
					// Feedback swap loads from the opposite result
					s_next.acc[unit][0] =
						s_reg.ctrl[unit][0][`DLI_B_XRESULT] ?
						res[unit][1] : res[unit][0]; // RQ5 RQ12 RQ14
					s_next.acc[unit][1] =
						s_reg.ctrl[unit][1][`DLI_B_XRESULT] ?
						res[unit][0] : res[unit][1]; // RQ5 RQ12 RQ14
				end
			end
			// Write data phase, zero wait states
			dli_pkg::DLI_WR: begin
				unique case (ofs)
					`DLI_OFS_ACC0: s_next.acc[unit][0] = hwdata;
					`DLI_OFS_ACC1: s_next.acc[unit][1] = hwdata;
					`DLI_OFS_ADDEND_REG_ZERO: s_next.base[unit][0] = hwdata;
					`DLI_OFS_ADDEND_REG_ONE: s_next.base[unit][1] = hwdata;
					`DLI_OFS_ADDEND_REG_TWO: s_next.base[unit][2] = hwdata;
					`DLI_OFS_CTRL0: s_next.ctrl[unit][0] = hwdata &
						`DLI_CTRL0_WMASK;
					`DLI_OFS_CTRL1: s_next.ctrl[unit][1] = hwdata &
						`DLI_CTRL1_WMASK;
					`DLI_OFS_ADD0: s_next.acc[unit][0] =
						s_reg.acc[unit][0] + hwdata; // RQ3
					`DLI_OFS_ADD1: s_next.acc[unit][1] =
						s_reg.acc[unit][1] + hwdata; // RQ3
					// Result locations are read only, others unmapped
					default: s_next.acc = s_reg.acc; // RQ4
				endcase
			end
			default: s_next.phase = s_reg.phase;
		endcase
		// New address phase, accepted whenever the slave is ready
		if (s_reg.phase != dli_pkg::DLI_RD_WAIT) begin
			s_next.phase = dli_pkg::DLI_IDLE;
			if (take) begin
				s_next.addr = haddr[6:0];
				s_next.phase = hwrite ? dli_pkg::DLI_WR :
					dli_pkg::DLI_RD_WAIT;
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Both units start cleared, controls at full mask
			s_reg.acc <= '0; // RQ1
			s_reg.base <= '0;
			s_reg.ctrl <= {4{`DLI_CTRL_RESET}};
			s_reg.phase <= dli_pkg::DLI_IDLE;
			s_reg.addr <= 7'h00;
			s_reg.rdata <= `DLI_WORD_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Bus outputs: stall only during the read wait cycle
	assign hreadyout = (s_reg.phase != dli_pkg::DLI_RD_WAIT); // RQ2
	assign hresp = 1'b0;
	assign hrdata = s_reg.rdata;

	default clocking dli_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Read accepted, one stall cycle, then ready
	sequence rd_taken;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_latency_two: assert property ( // RQ2
		rd_taken |=> rd_answer)
		else $error("read answer not after one stall cycle");
	a_view_no_change: assert property ( // RQ4
		s_reg.phase == dli_pkg::DLI_RD_WAIT && ofs >= `DLI_OFS_VIEW0 &&
		ofs <= `DLI_OFS_VIEW2 |=> $stable(s_reg.acc))
		else $error("result view read changed accumulators");
	a_advance_load: assert property ( // RQ5
		s_reg.phase == dli_pkg::DLI_RD_WAIT && ofs == `DLI_OFS_ADV0 &&
		!s_reg.ctrl[unit][0][`DLI_B_XRESULT] |=>
		s_reg.acc[$past(unit)][0] == $past(res[unit][0]) &&
		hrdata == $past(res[unit][0]))
		else $error("advance read did not load own result");
	a_swap_feedback: assert property ( // RQ12
		s_reg.phase == dli_pkg::DLI_RD_WAIT && ofs == `DLI_OFS_ADV1 &&
		s_reg.ctrl[unit][1][`DLI_B_XRESULT] |=>
		s_reg.acc[$past(unit)][1] == $past(res[unit][0]))
		else $error("feedback swap did not take other result");
	a_add_alias_sum: assert property ( // RQ3
		s_reg.phase == dli_pkg::DLI_WR && ofs == `DLI_OFS_ADD1 |=>
		s_reg.acc[$past(unit)][1] ==
		$past(s_reg.acc[unit][1]) + $past(hwdata))
		else $error("add alias did not accumulate");
	a_raw_read_value: assert property ( // RQ11
		s_reg.phase == dli_pkg::DLI_RD_WAIT && ofs == `DLI_OFS_ADD0 |=>
		hrdata == $past(lval[unit][0]))
		else $error("add alias read not raw lane value");
	a_third_sum: assert property ( // RQ7
		!s_reg.ctrl[1][0][`DLI_B_MODE] |->
		res[1][2] == s_reg.base[1][2] + lval[1][0] + lval[1][1])
		else $error("third result sum wrong");
	a_bypass_sum: assert property ( // RQ15
		s_reg.ctrl[1][1][`DLI_B_BYPASS] |->
		res[1][1] == s_reg.base[1][1] + lin[1][1])
		else $error("bypass result not raw input plus base");
	a_mask_low_bits: assert property ( // RQ9
		lval[1][0] == (lval[1][0] &
		(32'hFFFFFFFF << s_reg.ctrl[1][0][`DLI_F_MLOW +: 5])))
		else $error("bits below mask low kept");
	a_blend_third: assert property ( // RQ16
		s_reg.ctrl[0][0][`DLI_B_MODE] |->
		res[0][2] == s_reg.base[0][2] + lval[0][0])
		else $error("linear mode third result wrong");
	a_clamp_range: assert property ( // RQ17
		s_reg.ctrl[1][0][`DLI_B_MODE] && !s_reg.ctrl[1][0][`DLI_B_SIGNED] &&
		s_reg.base[1][0] <= s_reg.base[1][1] |->
		res[1][0] >= s_reg.base[1][0] && res[1][0] <= s_reg.base[1][1])
		else $error("range limit result outside bounds");

	// Write accepted on the bus, then its data phase
	sequence wr_taken;
		hsel && htrans[1] && hready && hwrite;
	endsequence
	sequence wr_data;
		s_reg.phase == dli_pkg::DLI_WR && hreadyout;
	endsequence

	// Writes never stall and land in the following data phase
	a_write_no_wait: assert property ( // RQ2
		wr_taken |=> wr_data)
		else $error("write data phase stalled");

	// Read data stands until the next read completes
	a_rdata_hold: assert property ( // RQ2
		s_reg.phase != dli_pkg::DLI_RD_WAIT |=> $stable(hrdata))
		else $error("read data changed outside a read");

	// Base write lands at the end of its data phase
	a_base_write: assert property ( // RQ1
		s_reg.phase == dli_pkg::DLI_WR && ofs == `DLI_OFS_ADDEND_REG_TWO |=>
		s_reg.base[$past(unit)][2] == $past(hwdata))
		else $error("base write did not land");

	// Lane zero add alias accumulates as well
	a_add_lane_zero: assert property ( // RQ3
		s_reg.phase == dli_pkg::DLI_WR && ofs == `DLI_OFS_ADD0 |=>
		s_reg.acc[$past(unit)][0] ==
		$past(s_reg.acc[unit][0]) + $past(hwdata))
		else $error("lane zero add alias did not accumulate");

	// A view read leaves bases and controls alone too
	a_view_keeps_cfg: assert property ( // RQ4
		s_reg.phase == dli_pkg::DLI_RD_WAIT &&
		ofs >= `DLI_OFS_VIEW0 && ofs <= `DLI_OFS_VIEW2 |=>
		$stable(s_reg.base) && $stable(s_reg.ctrl))
		else $error("result view read changed configuration");

	// Advance read also loads lane one from its own result
	a_advance_lane_one: assert property ( // RQ5
		s_reg.phase == dli_pkg::DLI_RD_WAIT && ofs == `DLI_OFS_ADV2 &&
		!s_reg.ctrl[unit][1][`DLI_B_XRESULT] |=>
		s_reg.acc[$past(unit)][1] == $past(res[unit][1]))
		else $error("advance read did not load lane one");

	// Feedback swap on lane zero takes result one
	a_swap_lane_zero: assert property ( // RQ12
		s_reg.phase == dli_pkg::DLI_RD_WAIT && ofs == `DLI_OFS_ADV0 &&
		s_reg.ctrl[unit][0][`DLI_B_XRESULT] |=>
		s_reg.acc[$past(unit)][0] == $past(res[unit][1]))
		else $error("lane zero swap did not take result one");

	// Result zero in normal mode without bypass
	a_result_zero: assert property ( // RQ7
		!s_reg.ctrl[1][0][`DLI_B_MODE] &&
		!s_reg.ctrl[1][0][`DLI_B_BYPASS] |->
		res[1][0] == s_reg.base[1][0] + lval[1][0])
		else $error("result zero sum wrong");

	// Third result of the first unit in normal mode
	a_third_sum_zero: assert property ( // RQ6
		!s_reg.ctrl[0][0][`DLI_B_MODE] |->
		res[0][2] == s_reg.base[0][2] + lval[0][0] + lval[0][1])
		else $error("first unit third result wrong");

	// Input swap selects the other accumulator
	a_input_swap: assert property ( // RQ13
		s_reg.ctrl[1][0][`DLI_B_XINPUT] |->
		lin[1][0] == s_reg.acc[1][1])
		else $error("input swap did not take other accumulator");

	// Full unsigned mask leaves only the shifted input
	a_shift_only: assert property ( // RQ8
		s_reg.ctrl[1][1][`DLI_F_MLOW +: 10] == 10'h3E0 &&
		!s_reg.ctrl[1][1][`DLI_B_SIGNED] |->
		lval[1][1] == (lin[1][1] >> s_reg.ctrl[1][1][`DLI_F_SHIFT +: 5]))
		else $error("lane value not the shifted input");

	// Sign extension fills every bit above the high mask bit
	a_sign_fill: assert property ( // RQ10
		s_reg.ctrl[1][1][`DLI_B_SIGNED] &&
		lval[1][1][s_reg.ctrl[1][1][`DLI_F_MHIGH +: 5]] |->
		(lval[1][1] | (32'hFFFFFFFF >>
		(5'h1F - s_reg.ctrl[1][1][`DLI_F_MHIGH +: 5]))) == 32'hFFFFFFFF)
		else $error("sign extension left upper bits clear");

	// Raw read of the lane one add alias
	a_raw_lane_one: assert property ( // RQ11
		s_reg.phase == dli_pkg::DLI_RD_WAIT && ofs == `DLI_OFS_ADD1 |=>
		hrdata == $past(lval[unit][1]))
		else $error("lane one add alias read not raw value");

	// Bits outside the lane controls stay clear
	a_ctrl_reserved: assert property ( // RQ14
		(s_reg.ctrl[1][1] & ~`DLI_CTRL1_WMASK) == 32'h00000000)
		else $error("reserved control bits set");

	// Blend mode result zero is the alpha byte
	a_blend_alpha: assert property ( // RQ18
		s_reg.ctrl[0][0][`DLI_B_MODE] |->
		res[0][0] == {24'h000000, lval[0][1][7:0]})
		else $error("blend result zero not alpha");

	// Range limit passes an in range value through
	a_clamp_pass: assert property ( // RQ17
		s_reg.ctrl[1][0][`DLI_B_MODE] && !s_reg.ctrl[1][0][`DLI_B_SIGNED] &&
		lval[1][0] >= s_reg.base[1][0] && lval[1][0] <= s_reg.base[1][1] |->
		res[1][0] == lval[1][0])
		else $error("range limit changed an in range value");
endmodule

// ==== rtl/dli_cfg.svh ====
// Constants of the dual lane interpolator: map, fields, resets
// Operation
// RQ1 - Core owns two units, two accumulators, three bases
// RQ2 - Register access single cycle, results ready next; reads here take one stall cycle
// RQ3 - Add alias write adds to accumulator
// RQ4 - Result view reads are side effect free
// RQ5 - Result advance read returns view, loads accumulators
// RQ6 - Results are lane values plus base registers
// RQ7 - Result sums: addend_reg_zero+lane0, addend_reg_one+lane1, addend_reg_two+both
// RQ8 - Lane order: right shift, mask, sign extend
// RQ9 - Mask keeps bits low to high inclusive
// RQ10 - Sign extend copies high mask bit upward
// RQ11 - Add alias read returns raw lane value
// RQ12 - Feedback swap loads accumulator from other result
// RQ13 - Input swap picks other accumulator as input
// RQ14 - Four per lane multiplexer control flags
// RQ15 - Bypass adds unshifted input to own base
// RQ16 - Linear mode third result excludes lane one
// RQ17 - Range limit clamps lane zero between bases
// RQ18 - Linear mode blends bases by lane one byte
`ifndef DLI_CFG_SVH
`define DLI_CFG_SVH
// Unit select bit of the byte address and word offsets within a unit
`define DLI_UNIT_BIT 6
`define DLI_OFS_ACC0 6'h00
`define DLI_OFS_ACC1 6'h04
`define DLI_OFS_ADDEND_REG_ZERO 6'h08
`define DLI_OFS_ADDEND_REG_ONE 6'h0C
`define DLI_OFS_ADDEND_REG_TWO 6'h10
`define DLI_OFS_VIEW0 6'h14
`define DLI_OFS_VIEW1 6'h18
`define DLI_OFS_VIEW2 6'h1C
`define DLI_OFS_ADV0 6'h20
`define DLI_OFS_ADV1 6'h24
`define DLI_OFS_ADV2 6'h28
`define DLI_OFS_CTRL0 6'h2C
`define DLI_OFS_CTRL1 6'h30
`define DLI_OFS_ADD0 6'h34
`define DLI_OFS_ADD1 6'h38
// Lane control field positions
`define DLI_F_SHIFT 0
`define DLI_F_MLOW 5
`define DLI_F_MHIGH 10
`define DLI_B_SIGNED 15
`define DLI_B_XINPUT 16
`define DLI_B_XRESULT 17
`define DLI_B_BYPASS 18
`define DLI_B_MODE 19
// Writable bits per lane control register and reset values
`define DLI_CTRL0_WMASK 32'h000FFFFF
`define DLI_CTRL1_WMASK 32'h0007FFFF
`define DLI_CTRL_RESET 32'h00007C00
`define DLI_WORD_RESET 32'h00000000
`endif

// ==== rtl/dli_pkg.sv ====
// Types of the dual lane interpolator
package dli_pkg;
	// Bus phase tracker, Gray coded along idle, read wait, read done
	typedef enum logic [1:0] {
		DLI_IDLE = 2'b00,
		DLI_RD_WAIT = 2'b01,
		DLI_RD_DONE = 2'b11,
		DLI_WR = 2'b10
	} dli_phase_e;
	typedef logic [31:0] dli_word_t;
	// All state of the interpolator pair and its bus slave
	typedef struct packed {
		dli_word_t [1:0][1:0] acc; // Accumulators [unit][lane]
		dli_word_t [1:0][2:0] base; // Addends [unit][index]
		dli_word_t [1:0][1:0] ctrl; // Lane controls [unit][lane]
		dli_phase_e phase; // Data phase in progress
		logic [6:0] addr; // Captured byte address
		dli_word_t rdata; // Registered read data
	} dli_state_s;
endpackage

// ==== sim/dli_core_model.sv ====
// Processor core model issuing single word register transfers
`timescale 1ns/1ps
module dli_core_model (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	logic rdy_s; // Ready as seen just before the next rising edge
	logic [31:0] rdata_s; // Read data as seen just before the next edge

	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end

	// Mid-cycle capture avoids racing the slave's edge updates
	always @(negedge hclk) begin
		rdy_s = hready;
		rdata_s = hrdata;
	end

	// One whole word transfer; entered right after a rising edge
	task automatic xfer(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		hsize <= 3'h2;
		@(posedge hclk);
		// Address phase held until ready is seen high
		while (rdy_s !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		// Reads leave the data bus changing so stale data never matches
		hwdata <= w ? d : ~hwdata;
		@(posedge hclk);
		// Data phase held until ready is seen high
		while (rdy_s !== 1'b1) @(posedge hclk);
		r = rdata_s;
	endtask
endmodule

// ==== sim/dli_interp_tb.sv ====
// Self-checking testbench of the interpolator pair
`timescale 1ns/1ps
module dli_interp_tb;
	logic hclk, hresetn, hsel, hwrite;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, p, q, t;
	wire hready; // Slave's ready fed back as bus ready
	wire [31:0] hrdata;
	wire hresp; // Slave response, always okay
	int num_errors, checks_done, i;

	dli_core_model dli_core_model_inst (.hclk(hclk), .hready(hready),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	dli_interp dli_interp_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata));

	// Compare one word and count it
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// Register write
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		dli_core_model_inst.xfer(1'b1, a, d, r);
	endtask

	// Register read with comparison
	task automatic rdc(input logic [31:0] a, e);
		logic [31:0] r;
		dli_core_model_inst.xfer(1'b0, a, 32'h00000000, r);
		chk($sformatf("read at %h", a), e, r);
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Clock of 100 ns
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (4000) @(posedge hclk);
		num_errors++;
		end_of_test();
	end

	// Main sequence
	initial begin
		num_errors = 0;
		checks_done = 0;
		hresetn = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(32'h2C, 32'h00007C00);
		rdc(32'h00, 32'h00000000);
		rdc(32'h3C, 32'h00000000);
		// Shift 8, mask 4..7, signed
		wr(32'h00, 32'hDEADBEEF);
		wr(32'h2C, 32'h00009C88);
		rdc(32'h34, 32'hFFFFFFB0);
		wr(32'h2C, 32'h00001C88);
		rdc(32'h34, 32'h000000B0);
		// Moving nibble mask
		wr(32'h00, 32'h1234ABCD);
		for (i = 0; i < 8; i++) begin
			wr(32'h2C, ((i * 4) << 5) | ((i * 4 + 3) << 10));
			rdc(32'h34, 32'h1234ABCD & (32'hF << (4 * i)));
		end
		// Add alias accumulates
		wr(32'h04, 32'h00000005);
		wr(32'h38, 32'h00000003);
		rdc(32'h04, 32'h00000008);
		// Three result sums
		wr(32'h2C, 32'h00007C00);
		wr(32'h00, 32'h0000000A);
		wr(32'h04, 32'h00000014);
		wr(32'h08, 32'h00000064);
		wr(32'h0C, 32'h000000C8);
		wr(32'h10, 32'h000003E8);
		rdc(32'h14, 32'h0000006E);
		rdc(32'h18, 32'h000000DC);
		rdc(32'h1C, 32'h00000406);
		// Lane one takes the other accumulator
		wr(32'h30, 32'h00017C00);
		rdc(32'h18, 32'h000000D2);
		rdc(32'h1C, 32'h000003FC);
		wr(32'h30, 32'h00007C00);
		// Bypass on lane zero with shift 4
		wr(32'h2C, 32'h00047C04);
		wr(32'h00, 32'h00000100);
		rdc(32'h14, 32'h00000164);
		rdc(32'h1C, 32'h0000040C);
		wr(32'h2C, 32'h00007C00);
		// Counting by nine through advance reads
		wr(32'h00, 32'h00000000);
		wr(32'h08, 32'h00000009);
		wr(32'h14, 32'h0000FFFF);
		rdc(32'h14, 32'h00000009);
		rdc(32'h14, 32'h00000009);
		for (i = 1; i < 4; i++) begin
			rdc(32'h20, 32'(9 * i));
		end
		rdc(32'h04, 32'h0000026C);
		// Crossed results feed the opposite accumulators
		wr(32'h2C, 32'h00027C00);
		wr(32'h30, 32'h00027C00);
		wr(32'h00, 32'd123);
		wr(32'h04, 32'd456);
		wr(32'h08, 32'h00000001);
		wr(32'h0C, 32'h00000000);
		p = 32'd123;
		q = 32'd456;
		for (i = 0; i < 4; i++) begin
			rdc(32'h14, p + 32'h1);
			rdc(32'h24, q);
			t = q;
			q = p + 32'h1;
			p = t;
		end
		// Blend on the first unit, alpha 0x80
		wr(32'h2C, 32'h00087C00);
		wr(32'h30, 32'h00007C00);
		wr(32'h00, 32'h00000007);
		wr(32'h04, 32'h00000080);
		wr(32'h08, 32'd500);
		wr(32'h0C, 32'd1000);
		rdc(32'h14, 32'h00000080);
		rdc(32'h18, 32'h000002EE);
		rdc(32'h1C, 32'h000003EF);
		// Range limit on the second unit between 10 and 50
		wr(32'h6C, 32'h00087C00);
		wr(32'h48, 32'h0000000A);
		wr(32'h4C, 32'h00000032);
		wr(32'h40, 32'h00000064);
		rdc(32'h54, 32'h00000032);
		wr(32'h40, 32'h00000003);
		rdc(32'h54, 32'h0000000A);
		wr(32'h40, 32'h00000014);
		rdc(32'h54, 32'h00000014);
		rdc(32'h00, 32'h00000007);
		chk("hresp", 32'h00000000, {31'h00000000, hresp});
		end_of_test();
	end
endmodule
